// ===== rtl/fipc_pkg.sv
// Package with constants and carrier types of the fault interrupt and link check block.
`default_nettype none
package fipc_pkg;
  localparam int          CLK_MHZ          = 100;
  localparam int          DEB_SHORT_NS     = 12800;
  localparam int          DEB_LONG_NS      = 51200;
  localparam int          DEB_SHORT_CYC    = (DEB_SHORT_NS * CLK_MHZ + 999) / 1000;
  localparam int          DEB_LONG_CYC     = (DEB_LONG_NS * CLK_MHZ + 999) / 1000;
  localparam int          LPF_250HZ_SHIFT  = 12;
  localparam int          LPF_500HZ_SHIFT  = 11;
  localparam int          LPF_1KHZ_SHIFT   = 10;
  localparam logic [7:0]  CRC_INIT         = 8'h00;
  localparam logic [7:0]  CRC_POLY         = 8'h07;
  localparam logic [7:0]  FLAGS_RESET      = 8'h00;
  localparam int          FLAGS_W          = 8;

  typedef enum logic [1:0] {FIPC_LPF_250, FIPC_LPF_500, FIPC_LPF_1K} fipc_lpf_e;
  typedef enum {FIPC_IDLE, FIPC_ADDR, FIPC_DATA} fipc_link_e;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       is_write;
  } fipc_byte_s;
endpackage : fipc_pkg
`default_nettype wire

// ===== rtl/fipc_ctrl.sv
// Fault flag, interrupt, mode select and link check logic of the voltage supervisor.
`default_nettype none
module fipc_ctrl
  import fipc_pkg::*;
#(
  parameter int NCH = 4
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               activity_select,
  output logic                    active_mode,
  input  wire logic [NCH-1:0]     ov_raw,
  input  wire logic [NCH-1:0]     uv_raw,
  input  wire logic               ov_deb_long,
  input  wire logic               uv_deb_long,
  input  wire logic [NCH-1:0]     low_freq_path,
  input  wire logic [1:0]         lpf_sel,
  input  wire logic [FLAGS_W-1:0] clr_first,
  input  wire logic [FLAGS_W-1:0] clr_second,
  input  wire logic [FLAGS_W-1:0] mask_first,
  input  wire logic [FLAGS_W-1:0] mask_second,
  output logic [FLAGS_W-1:0]      fault_flags_first,
  output logic [FLAGS_W-1:0]      fault_flags_second,
  input  wire logic               check_en,
  input  wire fipc_byte_s         link_byte,
  input  wire logic               link_byte_vld,
  input  wire logic               link_stop,
  output logic                    write_commit,
  output logic                    write_discard,
  output logic [7:0]              crc_value,
  output logic                    fault_irq_n_o,
  output logic                    fault_irq_n_oe
);
  localparam int LPF_W = 13;
  localparam int DW    = $clog2(DEB_LONG_CYC + 1);

  // The flag banks hold four channels of each fault kind, so more channels cannot be served.
  initial begin
    if (NCH < 1 || NCH > 4) $error("NCH must be 1 to 4");
    if (2 * NCH > FLAGS_W) $error("flag bank too narrow for NCH");
    if (LPF_W <= LPF_250HZ_SHIFT) $error("filter accumulator too narrow");
    if (DEB_LONG_CYC >= (1 << DW)) $error("debounce counter too narrow");
  end

  // All registers of the block live in this struct; nxt_ff holds its next value.
  typedef struct packed {
    logic [2:0]             act_sync;
    logic [NCH-1:0]         ov_s1, ov_s2, uv_s1, uv_s2, lf_s1, lf_s2;
    logic [NCH-1:0][DW-1:0] ov_cnt, uv_cnt;
    logic [NCH-1:0][LPF_W-1:0] lf_acc;
    logic [FLAGS_W-1:0]     flags1, flags2;
    logic [7:0]             crc;
    logic                   in_txn, good_seen, extra_seen, pend_err, err_event;
    logic                   commit, discard;
  } fipc_state_s;

  fipc_state_s cur_ff, nxt_ff;

  // One byte of the link check code, most significant bit first.
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc_step

  always_comb begin
    logic [DW-1:0]    ov_lim;
    logic [DW-1:0]    uv_lim;
    logic [NCH-1:0]   ov_hit;
    logic [NCH-1:0]   uv_hit;
    logic [NCH-1:0]   lf_hit;
    logic [FLAGS_W-1:0] set1;
    logic [FLAGS_W-1:0] set2;
    int               sh;
    logic [LPF_W-1:0] tgt;
    logic [LPF_W-1:0] diff;
    logic [LPF_W-1:0] step;
    sh     = LPF_1KHZ_SHIFT;
    tgt    = '0;
    diff   = '0;
    step   = '0;
    nxt_ff = cur_ff;
    ov_hit = '0;
    uv_hit = '0;
    lf_hit = '0;
    set1   = '0;
    set2   = '0;
    // Each overvoltage and undervoltage fault must stay present for the whole debounce count before it is taken.
    ov_lim = ov_deb_long ? DW'(DEB_LONG_CYC) : DW'(DEB_SHORT_CYC);
    uv_lim = uv_deb_long ? DW'(DEB_LONG_CYC) : DW'(DEB_SHORT_CYC);
    case (fipc_lpf_e'(lpf_sel))
      FIPC_LPF_250: sh = LPF_250HZ_SHIFT;
      FIPC_LPF_500: sh = LPF_500HZ_SHIFT;
      default:      sh = LPF_1KHZ_SHIFT;
    endcase
    // Pins from outside the clock domain pass a synchroniser before any logic reads them.
    // Activity select has a third stage, so the mode follows the pin three cycles later, one more than the other pins.
    nxt_ff.act_sync = {cur_ff.act_sync[1:0], activity_select};
    nxt_ff.ov_s1 = ov_raw;
    nxt_ff.ov_s2 = cur_ff.ov_s1;
    nxt_ff.uv_s1 = uv_raw;
    nxt_ff.uv_s2 = cur_ff.uv_s1;
    nxt_ff.lf_s1 = low_freq_path;
    nxt_ff.lf_s2 = cur_ff.lf_s1;
    for (int c = 0; c < NCH; c++) begin
      // Faults are only detected in active mode.
      // A counter stops at its limit and restarts from zero once the fault goes away.
      if (cur_ff.ov_s2[c] && cur_ff.act_sync[2]) begin
        if (cur_ff.ov_cnt[c] < ov_lim) nxt_ff.ov_cnt[c] = cur_ff.ov_cnt[c] + DW'(1);
        else ov_hit[c] = 1'b1;
      end else begin
        nxt_ff.ov_cnt[c] = '0;
      end
      if (cur_ff.uv_s2[c] && cur_ff.act_sync[2]) begin
        if (cur_ff.uv_cnt[c] < uv_lim) nxt_ff.uv_cnt[c] = cur_ff.uv_cnt[c] + DW'(1);
        else uv_hit[c] = 1'b1;
      end else begin
        nxt_ff.uv_cnt[c] = '0;
      end
      // First order low pass: the accumulator tracks the fault level with a shift set gain.
      tgt  = cur_ff.lf_s2[c] ? {LPF_W{1'b1}} : '0;
      diff = (tgt > cur_ff.lf_acc[c]) ? tgt - cur_ff.lf_acc[c] : cur_ff.lf_acc[c] - tgt;
      step = diff >> sh;
      // A step of at least one keeps the filter from stalling short of its target.
      if (step == '0 && diff != '0)
        step = LPF_W'(1);
      if (tgt > cur_ff.lf_acc[c])
        nxt_ff.lf_acc[c] = cur_ff.lf_acc[c] + step;
      else
        nxt_ff.lf_acc[c] = cur_ff.lf_acc[c] - step;
      lf_hit[c] = cur_ff.lf_acc[c][LPF_W-1] && cur_ff.act_sync[2];
    end
    set1[NCH-1:0]         = ov_hit;
    set1[2*NCH-1:NCH]     = uv_hit;
    set2[NCH-1:0]         = lf_hit;
    set2[FLAGS_W-1]       = cur_ff.err_event;
    // A set in the same cycle as a clear wins, so a fresh fault is never lost.
    nxt_ff.flags1 = (cur_ff.flags1 & ~clr_first) | set1;
    nxt_ff.flags2 = (cur_ff.flags2 & ~clr_second) | set2;

    // The first byte of a transaction restarts the code; with checking on, a byte
    // marked last is the check byte, and link_stop closes the transaction.
    nxt_ff.err_event = 1'b0;
    nxt_ff.commit    = 1'b0;
    nxt_ff.discard   = 1'b0;
    if (link_byte_vld) begin
      if (!cur_ff.in_txn) begin
        nxt_ff.crc        = crc_step(CRC_INIT, link_byte.data);
        nxt_ff.in_txn     = 1'b1;
        nxt_ff.good_seen  = 1'b0;
        nxt_ff.extra_seen = 1'b0;
        if (cur_ff.pend_err) begin
          nxt_ff.err_event = 1'b1;
          nxt_ff.pend_err  = 1'b0;
        end
      end else if (check_en && cur_ff.good_seen) begin
        nxt_ff.extra_seen = 1'b1;
      end else if (check_en && link_byte.last) begin
        // A bad check byte is only remembered; its flag waits for the next transaction.
        if (link_byte.data == cur_ff.crc) nxt_ff.good_seen = 1'b1;
        else nxt_ff.pend_err = 1'b1;
      end else begin
        nxt_ff.crc = crc_step(cur_ff.crc, link_byte.data);
      end
    end
    if (link_stop && cur_ff.in_txn) begin
      nxt_ff.in_txn = 1'b0;
      if (cur_ff.extra_seen) begin
        nxt_ff.discard   = 1'b1;
        nxt_ff.err_event = 1'b1;
      end else if (!check_en || cur_ff.good_seen) begin
        nxt_ff.commit = 1'b1;
      end else begin
        // Without a good check byte the write is dropped while checking is on.
        nxt_ff.discard = 1'b1;
      end
    end
  end

  // Reset returns every register to idle and leaves both flag banks empty.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff        <= '0;
      cur_ff.flags1 <= FLAGS_RESET;
      cur_ff.flags2 <= FLAGS_RESET;
      cur_ff.crc    <= CRC_INIT;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  // The pin is open drain: the block only pulls it low and the pull-up releases it.
  assign active_mode        = cur_ff.act_sync[2];
  assign fault_flags_first  = cur_ff.flags1;
  assign fault_flags_second = cur_ff.flags2;
  assign crc_value          = cur_ff.crc;
  assign write_commit       = cur_ff.commit;
  assign write_discard      = cur_ff.discard;
  assign fault_irq_n_o      = 1'b0;
  assign fault_irq_n_oe     = |(cur_ff.flags1 & ~mask_first) |
                              |(cur_ff.flags2 & ~mask_second);
endmodule : fipc_ctrl
`default_nettype wire

// ===== sim/fipc_ctrl_asserts.sv
// Port checks of the fault interrupt and link check block.
`default_nettype none
module fipc_ctrl_asserts import fipc_pkg::*; #(parameter int NCH = 4) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic activity_select,
  input wire logic active_mode,
  input wire logic [NCH-1:0] ov_raw,
  input wire logic [7:0] clr_first,
  input wire logic [7:0] clr_second,
  input wire logic [7:0] mask_first,
  input wire logic [7:0] mask_second,
  input wire logic [7:0] fault_flags_first,
  input wire logic [7:0] fault_flags_second,
  input wire logic write_commit,
  input wire logic write_discard,
  input wire logic fault_irq_n_oe,
  input wire logic check_en,
  input wire fipc_byte_s link_byte,
  input wire logic link_byte_vld,
  input wire logic link_stop
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Reference of the link check: notes a further byte after a good check byte.
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = {r[6:0], 1'h0} ^ (r[7] ? 8'h07 : 8'h00);
    return r;
  endfunction : crc8
  logic [7:0] crc_ff;
  logic       first_ff, good_ff, extra_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      crc_ff   <= 8'h00;
      first_ff <= 1'b1;
      good_ff  <= 1'b0;
      extra_ff <= 1'b0;
    end else if (link_byte_vld && first_ff) begin
      crc_ff   <= crc8(8'h00, link_byte.data);
      first_ff <= 1'b0;
      good_ff  <= 1'b0;
      extra_ff <= 1'b0;
    end else if (link_byte_vld && check_en && good_ff) begin
      extra_ff <= 1'b1;
    end else if (link_byte_vld && check_en && link_byte.last) begin
      good_ff <= (link_byte.data == crc_ff);
    end else if (link_byte_vld) begin
      crc_ff <= crc8(crc_ff, link_byte.data);
    end else if (link_stop) begin
      first_ff <= 1'b1;
    end
  end
  a_mode_active: assert property (activity_select [*5] |-> active_mode)
    else $error("no active mode");
  a_mode_sleep: assert property (!activity_select [*5] |-> !active_mode)
    else $error("no sleep mode");
  a_hold_first: assert property (
    (~fault_flags_first & $past(fault_flags_first) & ~$past(clr_first)) == 8'h00)
    else $error("first flag lost");
  a_hold_second: assert property (
    (~fault_flags_second & $past(fault_flags_second) & ~$past(clr_second)) == 8'h00)
    else $error("second flag lost");
  a_irq_level: assert property (
    fault_irq_n_oe == |(fault_flags_first & ~mask_first | fault_flags_second & ~mask_second))
    else $error("irq level wrong");
  a_commit_excl: assert property (!(write_commit && write_discard))
    else $error("commit with discard");
  a_disc_flag: assert property (
    write_discard && extra_ff |-> ##[0:1] fault_flags_second[7])
    else $error("discard without flag");
  a_flag_source: assert property (
    $rose(fault_flags_second[7]) |-> $past(write_discard) || $past(link_byte_vld, 2))
    else $error("check flag without cause");
  a_ov_debounce: assert property ($rose(fault_flags_first[0]) |-> $past(ov_raw[0], 8))
    else $error("flag without fault");
  c_commit: cover property (write_commit);
  c_discard: cover property (write_discard);
  c_irq: cover property ($rose(fault_irq_n_oe));
  c_extra: cover property (write_discard && extra_ff);
endmodule : fipc_ctrl_asserts
bind fipc_ctrl fipc_ctrl_asserts #(.NCH(NCH)) chk (.*);
`default_nettype wire

// ===== sim/fipc_host_model.sv
// Host controller model that sends link transactions with a check byte.
`default_nettype none
module fipc_host_model import fipc_pkg::*; (
  input wire logic clk,
  output var fipc_byte_s link_byte,
  output logic link_byte_vld,
  output logic link_stop
);
  initial begin
    link_byte = '0;
    link_byte_vld = 1'h0;
    link_stop = 1'h0;
  end
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++) c = {c[6:0], 1'h0} ^ (c[7] ? 8'h07 : 8'h00);
    return c;
  endfunction : crc
  task automatic put(input logic [7:0] d, input logic l);
    @(negedge clk);
    link_byte <= '{d, l, 1'h1};
    link_byte_vld <= 1'h1;
  endtask : put
  // Mode 0 sends a good check byte, 1 a wrong one, 2 a good one and a surplus byte.
  task automatic xfer(input logic [7:0] a, input logic [7:0] d, input int m);
    put(a, 1'h0);
    put(d, 1'h0);
    put(crc(crc(8'h00, a), d) ^ (m == 1 ? 8'hFF : 8'h00), 1'h1);
    if (m == 2) put(8'h5A, 1'h0);
    @(negedge clk);
    link_byte_vld <= 1'h0;
    link_byte.data <= ~link_byte.data;
    link_stop <= 1'h1;
    @(negedge clk);
    link_stop <= 1'h0;
  endtask : xfer
endmodule : fipc_host_model
`default_nettype wire

// ===== sim/fipc_ctrl_tb.sv
// Self-checking bench of the fault interrupt and link check block.
`default_nettype none
module fipc_ctrl_tb import fipc_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = '0, resetn = '0, activity_select = '0, ov_deb_long = '0, uv_deb_long = '0;
  logic check_en = '0, active_mode, link_byte_vld, link_stop, write_commit, write_discard;
  logic fault_irq_n_o, fault_irq_n_oe;
  logic [3:0] ov_raw = '0, uv_raw = '0, low_freq_path = '0;
  logic [1:0] lpf_sel = 2'h2;
  logic [7:0] clr_first = '0, clr_second = '0, mask_first = '0, mask_second = '0;
  logic [7:0] fault_flags_first, fault_flags_second, crc_value;
  fipc_byte_s link_byte;
  int mismatches = 0, checks = 0, commits = 0, discards = 0;
  fipc_ctrl dut (.*);
  fipc_host_model host (.*);
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (write_commit === 1'h1) commits++;
    if (write_discard === 1'h1) discards++;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic clr(input logic [15:0] v);
    {clr_second, clr_first} = v;
    cyc(1);
    {clr_second, clr_first} = '0;
    cyc(2);
  endtask : clr
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results
  task automatic t_fault;
    chk({7'h00, active_mode}, 8'h00);
    ov_raw[0] = 1'h1;
    cyc(1400);
    chk(fault_flags_first, 8'h00);
    activity_select = 1'h1;
    uv_deb_long = 1'h1;
    uv_raw[1] = 1'h1;
    cyc(1400);
    uv_raw[1] = 1'h0;
    chk(fault_flags_first, 8'h01);
    chk({7'h00, active_mode}, 8'h01);
    ov_raw[0] = 1'h0;
    cyc(20);
    chk(fault_flags_first, 8'h01);
    chk({7'h00, fault_irq_n_oe}, 8'h01);
    chk({7'h00, fault_irq_n_o}, 8'h00);
    mask_first = 8'h01;
    cyc(2);
    chk({7'h00, fault_irq_n_oe}, 8'h00);
    mask_first = 8'h00;
    clr(16'h0001);
    chk(fault_flags_first, 8'h00);
    uv_deb_long = 1'h0;
    uv_raw[1] = 1'h1;
    cyc(1300);
    uv_raw[1] = 1'h0;
    chk(fault_flags_first, 8'h20);
    clr(16'h0020);
  endtask : t_fault
  task automatic t_lowfreq;
    low_freq_path[2] = 1'h1;
    cyc(300);
    low_freq_path[2] = 1'h0;
    cyc(1500);
    chk(fault_flags_second, 8'h00);
    low_freq_path[2] = 1'h1;
    cyc(6000);
    low_freq_path[2] = 1'h0;
    cyc(2000);
    chk(fault_flags_second, 8'h04);
    clr(16'h0400);
    chk(fault_flags_second, 8'h00);
  endtask : t_lowfreq
  task automatic t_link;
    int n;
    n = commits;
    check_en = 1'h1;
    host.xfer(8'hA4, 8'h3C, 0);
    cyc(3);
    chk(8'(commits - n), 8'h01);
    chk(crc_value, host.crc(host.crc(8'h00, 8'hA4), 8'h3C));
    n = discards;
    host.xfer(8'hA4, 8'h3C, 1);
    cyc(3);
    chk(8'(discards - n), 8'h01);
    chk(fault_flags_second, 8'h00);
    host.xfer(8'hA4, 8'h11, 0);
    cyc(3);
    chk(fault_flags_second, 8'h80);
    clr(16'h8000);
    n = discards;
    host.xfer(8'hA4, 8'h22, 2);
    cyc(3);
    chk(8'(discards - n), 8'h01);
    chk(fault_flags_second, 8'h80);
    clr(16'h8000);
    check_en = 1'h0;
    n = commits;
    host.xfer(8'hA4, 8'h33, 1);
    host.xfer(8'hA4, 8'h44, 1);
    cyc(3);
    chk(8'(commits - n), 8'h02);
    chk(fault_flags_second, 8'h00);
  endtask : t_link
  initial begin
    cyc(12);
    resetn = 1'h1;
    chk(fault_flags_first | fault_flags_second, 8'h00);
    t_fault;
    t_lowfreq;
    t_link;
    results;
  end
  initial begin
    #300000;
    mismatches++;
    results;
  end
endmodule : fipc_ctrl_tb
`default_nettype wire
